// file: design/enc_router_defines.vh
// Constants shared by the encoder channel pin router design files.
`ifndef ENC_ROUTER_DEFINES_VH
`define ENC_ROUTER_DEFINES_VH

`define CHAN_COUNT        2
`define HALL_PER_CHAN     4
`define AVL_ADDR_W        5
`define AVL_DATA_W        32
`define AVL_BE_W          4

`define CTRL_BASE         5'h00
`define STAT_BASE         5'h10
`define REG_STRIDE        5'h04

`define CTRL_W            5
`define CTRL_STEP_BIT     0
`define CTRL_SER_BIT      1
`define CTRL_DEC_LSB      2
`define DEC_W             3
`define CTRL_RESET        5'h0C

`define DEC_PULSE_DIR_A   3'h0
`define DEC_PULSE_DIR_B   3'h4
`define DEC_QUAD_A        3'h3
`define DEC_QUAD_B        3'h7

`define HALL_T            0
`define HALL_U            1
`define HALL_V            2
`define HALL_W            3

`define STAT_W            17
`define STAT_ARM_BIT      0
`define STAT_TRIP_BIT     1
`define STAT_REL_BIT      2
`define STAT_A_BIT        3
`define STAT_B_BIT        4
`define STAT_IDX_BIT      5
`define STAT_HALL_LSB     6
`define STAT_PD_BIT       10
`define STAT_A_DRV_BIT    11
`define STAT_IDX_DRV_BIT  12
`define STAT_HDRV_LSB     13

`define SYNC_W            22

`endif

// file: design/bit_sync.v
// Two-flop synchroniser for a bundle of asynchronous pin levels.
`timescale 1ns/1ps
module bit_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk_sys_i,
  input  wire             rstn_i,
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_r;

  // Reset to zero so every jumper reads inactive until really sampled.
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_r <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule // bit_sync

// file: design/pin_drive_cell.v
// Registered pin drivers with active-low output enables.
`timescale 1ns/1ps
module pin_drive_cell #(
  parameter WIDTH = 1
) (
  input  wire             clk_sys_i,
  input  wire             rstn_i,
  input  wire [WIDTH-1:0] drive_en_i,
  input  wire [WIDTH-1:0] drive_val_i,
  output reg  [WIDTH-1:0] pin_o,
  output reg  [WIDTH-1:0] pin_oe_n_o
);

  // Enables reset released so no shared pin fights a sensor at power-on.
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_o      <= {WIDTH{1'b0}};
      pin_oe_n_o <= {WIDTH{1'b1}};
    end else begin
      pin_o      <= drive_val_i & drive_en_i;
      pin_oe_n_o <= ~drive_en_i;
    end
  end

endmodule // pin_drive_cell

// file: design/encoder_channel_pin_router.v
// Pin router for the shared encoder feedback pins of two channels.
//
// Contract
// R1 - Arm jumper on: drive-arm output goes out on the A pin.
// R2 - Trip jumper on: B pin feeds the drive-trip input, not phase B.
// R3 - Integrator keeps trip jumper off when trip comes from amplifier path.
// R4 - Step route select 1: step and direction drive the Hall/flag lines; the code does so only while serial route select is 0.
// R5 - Step route select resets to 0, Hall/flag lines stay inputs.
// R6 - Serial route select 1: serial data, clock, strobe reach their pins.
// R7 - Serial route select resets to 0, keeping shared pins free.
// R8 - Strobe-release jumper on: strobe withheld, pin stays index input.
// R9 - Decoder code 0 or 4: A and B are step and direction inputs.
// R10 - Other decoder codes, typically 3 or 7, decode A and B as quadrature.
// R11 - Channel setting index is hardware channel number minus one.
// R12 - After reset selects are default before any pin driver enables.
//
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`include "enc_router_defines.vh"
module encoder_channel_pin_router (
  input  wire                     clk_sys_i,
  input  wire                     rstn_i,
  input  wire [`AVL_ADDR_W-1:0]   avs_address_i,
  input  wire                     avs_read_i,
  input  wire                     avs_write_i,
  input  wire [`AVL_DATA_W-1:0]   avs_writedata_i,
  input  wire [`AVL_BE_W-1:0]     avs_byteenable_i,
  output reg  [`AVL_DATA_W-1:0]   avs_readdata_o,
  output wire                     avs_waitrequest_o,
  input  wire                     arm_jumper_first_i,
  input  wire                     arm_jumper_second_i,
  input  wire                     trip_jumper_first_i,
  input  wire                     trip_jumper_second_i,
  input  wire                     strobe_release_jumper_first_i,
  input  wire                     strobe_release_jumper_second_i,
  input  wire [`CHAN_COUNT-1:0]   quad_phase_a_pin_i,
  output wire [`CHAN_COUNT-1:0]   quad_phase_a_pin_o,
  output wire [`CHAN_COUNT-1:0]   quad_phase_a_pin_oe_n_o,
  input  wire [`CHAN_COUNT-1:0]   quad_phase_b_pin_i,
  input  wire [`CHAN_COUNT-1:0]   index_pin_i,
  output wire [`CHAN_COUNT-1:0]   index_pin_o,
  output wire [`CHAN_COUNT-1:0]   index_pin_oe_n_o,
  input  wire [2*`HALL_PER_CHAN-1:0] hall_flag_lines_i,
  output wire [2*`HALL_PER_CHAN-1:0] hall_flag_lines_o,
  output wire [2*`HALL_PER_CHAN-1:0] hall_flag_lines_oe_n_o,
  input  wire [`CHAN_COUNT-1:0]   trip_ext_i,
  input  wire [`CHAN_COUNT-1:0]   drive_arm_out_i,
  input  wire [`CHAN_COUNT-1:0]   step_pulse_i,
  input  wire [`CHAN_COUNT-1:0]   step_dir_i,
  input  wire [`CHAN_COUNT-1:0]   serial_clock_out_i,
  input  wire [`CHAN_COUNT-1:0]   serial_strobe_out_i,
  input  wire [`CHAN_COUNT-1:0]   serial_data_line_i,
  input  wire [`CHAN_COUNT-1:0]   serial_data_drive_i,
  output reg  [`CHAN_COUNT-1:0]   quad_phase_a_o,
  output reg  [`CHAN_COUNT-1:0]   quad_phase_b_o,
  output reg  [`CHAN_COUNT-1:0]   step_in_pulse_o,
  output reg  [`CHAN_COUNT-1:0]   step_in_dir_o,
  output reg  [`CHAN_COUNT-1:0]   pulse_dir_mode_o,
  output reg  [`CHAN_COUNT-1:0]   drive_trip_o,
  output reg  [2*`HALL_PER_CHAN-1:0] hall_flag_o,
  output reg  [`CHAN_COUNT-1:0]   index_capture_in_o,
  output reg  [`CHAN_COUNT-1:0]   serial_data_line_o,
  output wire [`CHAN_COUNT-1:0]   step_out_route_sel_o,
  output wire [`CHAN_COUNT-1:0]   serial_port_route_sel_o,
  output wire [2*`DEC_W-1:0]      decoder_type_sel_o
);

  localparam NCH  = `CHAN_COUNT;
  localparam NH   = `HALL_PER_CHAN;
  // Drivable pins per channel: four Hall/flag lines, A and index.
  localparam NPIN = NCH * (NH + 2);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Per-channel register address; index 0 is hardware channel 1.
  function [`AVL_ADDR_W-1:0] reg_addr;
    input [`AVL_ADDR_W-1:0] base;
    input                   chan_idx;
    begin
      reg_addr = chan_idx ? base + `REG_STRIDE : base; // R11
    end
  endfunction

  // Every code but the two pulse/direction codes decodes as quadrature.
  function is_pulse_dir;
    input [`DEC_W-1:0] code;
    begin
      is_pulse_dir = (code == `DEC_PULSE_DIR_A) ||
                     (code == `DEC_PULSE_DIR_B); // R9
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers for every pin and jumper level.
  // A pin reaches a decode output three edges late; slow sensor levels
  // can afford that, and no metastable level ever reaches the decode.

  wire [`SYNC_W-1:0] sync_in;
  wire [`SYNC_W-1:0] sync_out;
  wire [NCH-1:0]     arm_s;
  wire [NCH-1:0]     trip_s;
  wire [NCH-1:0]     rel_s;
  wire [NCH-1:0]     a_s;
  wire [NCH-1:0]     b_s;
  wire [NCH-1:0]     idx_s;
  wire [2*NH-1:0]    hall_s;
  wire [NCH-1:0]     ext_s;

  assign sync_in = {trip_ext_i, hall_flag_lines_i, index_pin_i,
                    quad_phase_b_pin_i, quad_phase_a_pin_i,
                    strobe_release_jumper_second_i,
                    strobe_release_jumper_first_i,
                    trip_jumper_second_i, trip_jumper_first_i,
                    arm_jumper_second_i, arm_jumper_first_i};

  assign arm_s  = sync_out[1:0];
  assign trip_s = sync_out[3:2];
  assign rel_s  = sync_out[5:4];
  assign a_s    = sync_out[7:6];
  assign b_s    = sync_out[9:8];
  assign idx_s  = sync_out[11:10];
  assign hall_s = sync_out[19:12];
  assign ext_s  = sync_out[21:20];

  bit_sync #(
    .WIDTH (`SYNC_W)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .async_i   (sync_in),
    .sync_o    (sync_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the access completes.
  // Waitrequest is combinational so the wait state costs no extra
  // cycle; the price is a path from the request inputs to waitrequest.

  reg                   ack_r;
  reg  [`CTRL_W-1:0]    ctrl0_r;
  reg  [`CTRL_W-1:0]    ctrl1_r;
  reg  [`AVL_DATA_W-1:0] rd_nxt;
  wire                  req;
  wire                  wr_go;
  wire                  lane0;
  wire [`STAT_W-1:0]    stat0;
  wire [`STAT_W-1:0]    stat1;
  wire                  hit_ctrl0;
  wire                  hit_ctrl1;
  wire                  hit_stat0;
  wire                  hit_stat1;

  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_r;
  assign wr_go             = avs_write_i & ack_r;
  assign lane0             = avs_byteenable_i[0];

  // One decode serves both the write and the read path.
  assign hit_ctrl0 = (avs_address_i == reg_addr(`CTRL_BASE, 1'b0)); // R11
  assign hit_ctrl1 = (avs_address_i == reg_addr(`CTRL_BASE, 1'b1)); // R11
  assign hit_stat0 = (avs_address_i == reg_addr(`STAT_BASE, 1'b0)); // R11
  assign hit_stat1 = (avs_address_i == reg_addr(`STAT_BASE, 1'b1)); // R11

  // Ack stands for exactly one cycle per request, ending the wait.
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // Defaults leave the Hall/flag and index pins inputs until software acts; the A pin follows the arm jumper.
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl0_r <= `CTRL_RESET; // R5 R7 R12
      ctrl1_r <= `CTRL_RESET; // R5 R7 R12
    end else if (wr_go && lane0) begin
      if (hit_ctrl0) begin
        ctrl0_r <= avs_writedata_i[`CTRL_W-1:0]; // R11
      end else if (hit_ctrl1) begin
        ctrl1_r <= avs_writedata_i[`CTRL_W-1:0]; // R11
      end
    end
  end

  // Unmapped addresses read zero and ignore writes.
  always @* begin
    rd_nxt = {`AVL_DATA_W{1'b0}};
    if (hit_ctrl0) begin
      rd_nxt[`CTRL_W-1:0] = ctrl0_r;
    end else if (hit_ctrl1) begin
      rd_nxt[`CTRL_W-1:0] = ctrl1_r;
    end else if (hit_stat0) begin
      rd_nxt[`STAT_W-1:0] = stat0;
    end else if (hit_stat1) begin
      rd_nxt[`STAT_W-1:0] = stat1;
    end
  end

  // Read data is loaded in the wait cycle so it stands when ready.
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avs_readdata_o <= {`AVL_DATA_W{1'b0}};
    end else if (avs_read_i && !ack_r) begin
      avs_readdata_o <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Route selection and pin drive per channel.

  wire [NCH*`CTRL_W-1:0] ctrl_all;
  wire [NCH-1:0]         step_sel;
  wire [NCH-1:0]         ser_sel;
  wire [NCH-1:0]         pd_mode;
  wire [NCH-1:0]         strobe_en;
  wire [2*NH-1:0]        hall_en;
  wire [2*NH-1:0]        hall_val;
  wire [NPIN-1:0]        drv_en;
  wire [NPIN-1:0]        drv_val;
  wire [NPIN-1:0]        pin_val;
  wire [NPIN-1:0]        pin_oe_n;

  // Channel fields sit side by side, index 0 in the low bits.
  assign ctrl_all = {ctrl1_r, ctrl0_r};

  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_chan
      wire [`DEC_W-1:0] dec;
      wire              step_on;
      wire              data_en;

      assign dec = ctrl_all[c*`CTRL_W+`CTRL_DEC_LSB +: `DEC_W];
      assign step_sel[c] = ctrl_all[c*`CTRL_W+`CTRL_STEP_BIT];
      assign ser_sel[c]  = ctrl_all[c*`CTRL_W+`CTRL_SER_BIT];
      assign decoder_type_sel_o[c*`DEC_W +: `DEC_W] = dec;
      assign pd_mode[c] = is_pulse_dir(dec); // R9 R10

      // Serial routing wins if software selects both, so the link
      // never shares its lines with the step generator.
      assign step_on = step_sel[c] & ~ser_sel[c]; // R4
      assign data_en = ser_sel[c] & serial_data_drive_i[c]; // R6
      assign strobe_en[c] = ser_sel[c] & ~rel_s[c]; // R6 R8

      // T carries the minus side and W the plus side of pulse or data;
      // U carries the plus side and V the minus side of dir or clock.
      assign hall_en[c*NH+`HALL_T] = data_en | step_on; // R4 R6
      assign hall_en[c*NH+`HALL_W] = data_en | step_on; // R4 R6
      assign hall_en[c*NH+`HALL_U] = ser_sel[c] | step_on; // R4 R6
      assign hall_en[c*NH+`HALL_V] = ser_sel[c] | step_on; // R4 R6

      assign hall_val[c*NH+`HALL_W] = ser_sel[c] ? serial_data_line_i[c]
                                                 : step_pulse_i[c];
      assign hall_val[c*NH+`HALL_T] = ~hall_val[c*NH+`HALL_W];
      assign hall_val[c*NH+`HALL_U] = ser_sel[c] ? serial_clock_out_i[c]
                                                 : step_dir_i[c];
      assign hall_val[c*NH+`HALL_V] = ~hall_val[c*NH+`HALL_U];

      // Status word for this channel, read-only.
      // Drive bits come from the registered enables, so they match pins.
      wire [`STAT_W-1:0] stat;
      assign stat[`STAT_ARM_BIT]  = arm_s[c];
      assign stat[`STAT_TRIP_BIT] = trip_s[c];
      assign stat[`STAT_REL_BIT]  = rel_s[c];
      assign stat[`STAT_A_BIT]    = a_s[c];
      assign stat[`STAT_B_BIT]    = b_s[c];
      assign stat[`STAT_IDX_BIT]  = idx_s[c];
      assign stat[`STAT_HALL_LSB +: NH] = hall_s[c*NH +: NH];
      assign stat[`STAT_PD_BIT]      = pd_mode[c];
      assign stat[`STAT_A_DRV_BIT]   = ~quad_phase_a_pin_oe_n_o[c];
      assign stat[`STAT_IDX_DRV_BIT] = ~index_pin_oe_n_o[c];
      assign stat[`STAT_HDRV_LSB +: NH] =
        ~hall_flag_lines_oe_n_o[c*NH +: NH];

      // Captured inputs toward the decoder, trip and flag logic.
      always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          quad_phase_a_o[c]     <= 1'b0;
          quad_phase_b_o[c]     <= 1'b0;
          step_in_pulse_o[c]    <= 1'b0;
          step_in_dir_o[c]      <= 1'b0;
          pulse_dir_mode_o[c]   <= 1'b0;
          drive_trip_o[c]       <= 1'b0;
          index_capture_in_o[c] <= 1'b0;
          serial_data_line_o[c] <= 1'b0;
          hall_flag_o[c*NH +: NH] <= {NH{1'b0}};
        end else begin
          // The A and B phases feed only one decoder at a time.
          quad_phase_a_o[c]   <= ~arm_s[c] & ~pd_mode[c] & a_s[c]; // R1 R10
          quad_phase_b_o[c]   <= ~trip_s[c] & ~pd_mode[c] & b_s[c]; // R2 R10
          step_in_pulse_o[c]  <= ~arm_s[c] & pd_mode[c] & a_s[c]; // R9
          step_in_dir_o[c]    <= ~trip_s[c] & pd_mode[c] & b_s[c]; // R9
          pulse_dir_mode_o[c] <= pd_mode[c]; // R9
          // A trip pin source and the amplifier path are never merged.
          drive_trip_o[c]     <= trip_s[c] ? b_s[c] : ext_s[c]; // R2 R3
          // Index capture is blind while the index pins carry the strobe.
          index_capture_in_o[c] <= ~strobe_en[c] & idx_s[c]; // R8
          // The data line is heard only while the link is not talking.
          serial_data_line_o[c] <= ser_sel[c] & ~data_en &
                                   hall_s[c*NH+`HALL_W]; // R6
          // A line that the router drives reads zero to the flag logic.
          hall_flag_o[c*NH +: NH] <= ~hall_en[c*NH +: NH] &
                                     hall_s[c*NH +: NH]; // R5
        end
      end
    end
  endgenerate

  // The status words are picked out of the generate scope by name.
  assign stat0 = g_chan[0].stat;
  assign stat1 = g_chan[1].stat;
  assign step_out_route_sel_o    = step_sel;
  assign serial_port_route_sel_o = ser_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Registered pin drivers; jumpers come through the synchroniser, so
  // the A pins cannot drive before two clean samples.
  // Registered drivers keep a select change from glitching a pin.

  assign drv_en  = {hall_en, strobe_en, arm_s}; // R1 R8 R12
  assign drv_val = {hall_val, serial_strobe_out_i, drive_arm_out_i};

  pin_drive_cell #(
    .WIDTH (NPIN)
  ) u_drive (
    .clk_sys_i   (clk_sys_i),
    .rstn_i      (rstn_i),
    .drive_en_i  (drv_en),
    .drive_val_i (drv_val),
    .pin_o       (pin_val),
    .pin_oe_n_o  (pin_oe_n)
  );

  // Driver slices: arm on the A pins, strobe on index, then Hall/flag.
  assign quad_phase_a_pin_o      = pin_val[NCH-1:0];
  assign quad_phase_a_pin_oe_n_o = pin_oe_n[NCH-1:0];
  assign index_pin_o             = pin_val[2*NCH-1:NCH];
  assign index_pin_oe_n_o        = pin_oe_n[2*NCH-1:NCH];
  assign hall_flag_lines_o       = pin_val[NPIN-1:2*NCH];
  assign hall_flag_lines_oe_n_o  = pin_oe_n[NPIN-1:2*NCH];

endmodule // encoder_channel_pin_router

// file: tb/enc_router_properties.sv
// Port-level assertions for the encoder channel pin router.
`timescale 1ns/1ps
module enc_router_properties (
  input logic       clk_sys_i,
  input logic       rstn_i,
  input logic       avs_read_i,
  input logic       avs_write_i,
  input logic       avs_waitrequest_o,
  input logic       arm_jumper_first_i,
  input logic       trip_jumper_second_i,
  input logic       strobe_release_jumper_second_i,
  input logic [1:0] quad_phase_a_pin_i,
  input logic [1:0] quad_phase_a_pin_o,
  input logic [1:0] quad_phase_a_pin_oe_n_o,
  input logic [1:0] quad_phase_b_pin_i,
  input logic [1:0] index_pin_oe_n_o,
  input logic [7:0] hall_flag_lines_o,
  input logic [7:0] hall_flag_lines_oe_n_o,
  input logic [1:0] drive_arm_out_i,
  input logic [1:0] step_pulse_i,
  input logic [1:0] step_dir_i,
  input logic [1:0] serial_clock_out_i,
  input logic [1:0] quad_phase_a_o,
  input logic [1:0] quad_phase_b_o,
  input logic [1:0] step_in_pulse_o,
  input logic [1:0] pulse_dir_mode_o,
  input logic [1:0] drive_trip_o,
  input logic [1:0] step_out_route_sel_o,
  input logic [1:0] serial_port_route_sel_o,
  input logic [5:0] decoder_type_sel_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // Jumpers cross two synchroniser stages, hence the long stable runs.
  sequence step_only_s;
    (step_out_route_sel_o[0] && !serial_port_route_sel_o[0])[*2];
  endsequence
  sequence strobe_rel_s;
    (serial_port_route_sel_o[1] && strobe_release_jumper_second_i)[*5];
  endsequence
  bus_wait_once_a: assert property ((avs_read_i || avs_write_i)
    && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("wait");
  arm_drive_a: assert property (arm_jumper_first_i[*5] |->
    !quad_phase_a_pin_oe_n_o[0] && quad_phase_a_pin_o[0] ==
    $past(drive_arm_out_i[0])) else $error("arm drive");
  arm_release_a: assert property (!arm_jumper_first_i[*5] |->
    quad_phase_a_pin_oe_n_o[0]) else $error("arm release");
  trip_route_a: assert property (trip_jumper_second_i[*6] |->
    drive_trip_o[1] == $past(quad_phase_b_pin_i[1], 3)
    && !quad_phase_b_o[1]) else $error("trip route");
  step_drive_a: assert property (step_only_s |->
    hall_flag_lines_oe_n_o[3:0] == 4'h0 && hall_flag_lines_o[3:0] ==
    {$past(step_pulse_i[0]), !$past(step_dir_i[0]),
    $past(step_dir_i[0]), !$past(step_pulse_i[0])}) else $error("step");
  hall_idle_a: assert property (!step_out_route_sel_o[1]
    && !serial_port_route_sel_o[1] ##1 !step_out_route_sel_o[1]
    && !serial_port_route_sel_o[1] |-> hall_flag_lines_oe_n_o[7:4] == 4'hF)
    else $error("hall idle");
  serial_clock_a: assert property (serial_port_route_sel_o[0][*2] |->
    hall_flag_lines_oe_n_o[2:1] == 2'b00 && hall_flag_lines_o[1] ==
    $past(serial_clock_out_i[0])) else $error("serial clock");
  strobe_hold_a: assert property (strobe_rel_s |->
    index_pin_oe_n_o[1]) else $error("strobe hold");
  pulse_dir_a: assert property ((decoder_type_sel_o[1:0] == 2'b00
    && !arm_jumper_first_i)[*6] |-> pulse_dir_mode_o[0] &&
    step_in_pulse_o[0] == $past(quad_phase_a_pin_i[0], 3))
    else $error("pulse dir");
  quad_mode_a: assert property ((decoder_type_sel_o[1:0] == 2'b11
    && !arm_jumper_first_i)[*6] |-> !pulse_dir_mode_o[0] &&
    quad_phase_a_o[0] == $past(quad_phase_a_pin_i[0], 3))
    else $error("quad mode");
endmodule // enc_router_properties

bind encoder_channel_pin_router enc_router_properties
  u_enc_router_properties (.*);

// file: tb/enc_far_side.sv
// Far-side model: encoder, index and Hall sources on the shared pins.
`timescale 1ns/1ps
module enc_far_side (
  input  logic [1:0] a_drv_i,
  input  logic [1:0] a_oe_n_i,
  input  logic [1:0] idx_drv_i,
  input  logic [1:0] idx_oe_n_i,
  input  logic [7:0] hall_drv_i,
  input  logic [7:0] hall_oe_n_i,
  input  logic [1:0] enc_a_i,
  input  logic [1:0] enc_b_i,
  input  logic [1:0] enc_idx_i,
  input  logic [7:0] enc_hall_i,
  output logic [1:0] a_line_o,
  output logic [1:0] b_line_o,
  output logic [1:0] idx_line_o,
  output logic [7:0] hall_line_o
);
  // Sources yield where the router drives, so no line is ever contended.
  assign a_line_o    = (a_oe_n_i & enc_a_i) | (~a_oe_n_i & a_drv_i);
  assign b_line_o    = enc_b_i;
  assign idx_line_o  = (idx_oe_n_i & enc_idx_i) | (~idx_oe_n_i & idx_drv_i);
  assign hall_line_o = (hall_oe_n_i & enc_hall_i) | (~hall_oe_n_i & hall_drv_i);
endmodule // enc_far_side

// file: tb/encoder_channel_pin_router_tb_top.sv
// Self-checking bench for the encoder channel pin router.
`timescale 1ns/1ps
module encoder_channel_pin_router_tb_top;
  logic        clk_sys_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic        arm_jumper_first_i, arm_jumper_second_i;
  logic        trip_jumper_first_i, trip_jumper_second_i;
  logic        strobe_release_jumper_first_i, strobe_release_jumper_second_i;
  logic [4:0]  avs_address_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [5:0]  decoder_type_sel_o, jmp;
  logic [7:0]  hall_flag_lines_i, hall_flag_lines_o, hall_flag_lines_oe_n_o;
  logic [7:0]  hall_flag_o, enc_hall;
  logic [1:0]  quad_phase_a_pin_i, quad_phase_a_pin_o, quad_phase_a_pin_oe_n_o;
  logic [1:0]  quad_phase_b_pin_i, index_pin_i, index_pin_o, index_pin_oe_n_o;
  logic [1:0]  trip_ext_i, drive_arm_out_i, step_pulse_i, step_dir_i;
  logic [1:0]  serial_clock_out_i, serial_strobe_out_i, serial_data_line_i;
  logic [1:0]  serial_data_drive_i, quad_phase_a_o, quad_phase_b_o;
  logic [1:0]  step_in_pulse_o, step_in_dir_o, pulse_dir_mode_o, drive_trip_o;
  logic [1:0]  index_capture_in_o, serial_data_line_o, step_out_route_sel_o;
  logic [1:0]  serial_port_route_sel_o, enc_a, enc_b, enc_idx;
  logic [63:0] rnd;
  int          mismatches, tests_run, i, c, ctl[2];
  int          dec_q[$] = '{0, 3, 4, 7};
  assign jmp = {strobe_release_jumper_second_i, strobe_release_jumper_first_i,
    trip_jumper_second_i, trip_jumper_first_i, arm_jumper_second_i,
    arm_jumper_first_i};
  encoder_channel_pin_router u_encoder_channel_pin_router (.*);
  enc_far_side u_enc_far_side (
    .a_drv_i(quad_phase_a_pin_o), .a_oe_n_i(quad_phase_a_pin_oe_n_o),
    .idx_drv_i(index_pin_o), .idx_oe_n_i(index_pin_oe_n_o),
    .hall_drv_i(hall_flag_lines_o), .hall_oe_n_i(hall_flag_lines_oe_n_o),
    .enc_a_i(enc_a), .enc_b_i(enc_b), .enc_idx_i(enc_idx),
    .enc_hall_i(enc_hall), .a_line_o(quad_phase_a_pin_i),
    .b_line_o(quad_phase_b_pin_i), .idx_line_o(index_pin_i),
    .hall_line_o(hall_flag_lines_i));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [63:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // The request stands until waitrequest is seen low at a rising edge;
  // read data is taken at that edge and the request drops there.
  task automatic bus_xfer(input logic wr, input logic [4:0] a,
      input logic [31:0] d, input logic [3:0] be, input logic [31:0] exp);
    @(posedge clk_sys_i);
    {avs_address_i, avs_writedata_i, avs_byteenable_i} <= {a, d, be};
    {avs_read_i, avs_write_i} <= {!wr, wr};
    do
      @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0);
    if (!wr)
      check("readdata", avs_readdata_o, exp);
    {avs_read_i, avs_write_i} <= 2'b00;
  endtask
  task automatic set_inputs(input logic [63:0] r);
    {strobe_release_jumper_second_i, strobe_release_jumper_first_i,
      trip_jumper_second_i, trip_jumper_first_i, arm_jumper_second_i,
      arm_jumper_first_i} <= r[5:0];
    trip_ext_i <= r[7:6] & ~r[3:2];
    {enc_a, enc_b, enc_idx, enc_hall, drive_arm_out_i, step_pulse_i}
      <= r[25:8];
    {step_dir_i, serial_clock_out_i, serial_strobe_out_i, serial_data_line_i,
      serial_data_drive_i} <= r[35:26];
  endtask
  task automatic model_check;
    logic [7:0] e_hoe, e_ho, e_hf;
    logic [1:0] e_aoe, e_ao, e_ioe, e_io, e_cap, e_qa, e_qb, e_sp, e_sd;
    logic [1:0] e_pd, e_tr;
    logic [3:0] hd, hv;
    logic       ser, stp, ae, b_eff, dd;
    for (c = 0; c < 2; c++) begin
      ser = ctl[c][1];
      stp = ctl[c][0] & ~ser;
      dd = serial_data_drive_i[c];
      e_aoe[c] = ~jmp[c];
      e_ao[c] = jmp[c] & drive_arm_out_i[c];
      e_ioe[c] = ~(ser & ~jmp[4+c]);
      e_io[c] = ~e_ioe[c] & serial_strobe_out_i[c];
      hd = stp ? 4'hF : {4{ser}} & {dd, 2'b11, dd};
      hv = stp ? {step_pulse_i[c], ~step_dir_i[c], step_dir_i[c],
        ~step_pulse_i[c]} : {serial_data_line_i[c], ~serial_clock_out_i[c],
        serial_clock_out_i[c], ~serial_data_line_i[c]};
      e_hoe[4*c+:4] = ~hd;
      e_ho[4*c+:4] = hv & hd;
      e_hf[4*c+:4] = enc_hall[4*c+:4] & ~hd;
      e_cap[c] = enc_idx[c] & e_ioe[c];
      ae = enc_a[c] & ~jmp[c];
      b_eff = enc_b[c] & ~jmp[2+c];
      e_tr[c] = jmp[2+c] ? enc_b[c] : trip_ext_i[c];
      e_pd[c] = (ctl[c][3:2] == 0);
      {e_qa[c], e_qb[c]} = {ae, b_eff} & {2{~e_pd[c]}};
      {e_sp[c], e_sd[c]} = {ae, b_eff} & {2{e_pd[c]}};
      if (ser && !dd)
        check("serial_in", serial_data_line_o[c], enc_hall[4*c+3]);
      bus_xfer(1'b0, 5'(16 + 4 * c), 32'h0, 4'hF, {15'h0,
        ~e_hoe[4*c+:4], ~e_ioe[c], ~e_aoe[c], e_pd[c],
        e_ho[4*c+:4] | e_hf[4*c+:4], e_io[c] | e_cap[c], enc_b[c],
        e_ao[c] | ae, jmp[4+c], jmp[2+c], jmp[c]});
    end
    check("pins", {quad_phase_a_pin_oe_n_o, quad_phase_a_pin_o,
      index_pin_oe_n_o, index_pin_o, hall_flag_lines_oe_n_o,
      hall_flag_lines_o}, {e_aoe, e_ao, e_ioe, e_io, e_hoe, e_ho});
    check("decode", {quad_phase_a_o, quad_phase_b_o, step_in_pulse_o,
      step_in_dir_o, pulse_dir_mode_o, drive_trip_o, index_capture_in_o,
      hall_flag_o}, {e_qa, e_qb, e_sp, e_sd, e_pd, e_tr, e_cap, e_hf});
    check("route", {decoder_type_sel_o, serial_port_route_sel_o,
      step_out_route_sel_o}, {ctl[1][4:2], ctl[0][4:2], ctl[1][1], ctl[0][1],
      ctl[1][0], ctl[0][0]});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #100000;
    mismatches++;
    complete_run();
  end
  initial begin
    {rstn_i, avs_read_i, avs_write_i, avs_address_i} = '0;
    {avs_byteenable_i, avs_writedata_i} = '0;
    ctl[0] = 32'h0C;
    ctl[1] = 32'h0C;
    set_inputs(64'h0);
    void'($urandom(44));
    repeat (10) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    #1;
    model_check();
    bus_xfer(1'b0, 5'h04, 32'h0, 4'hF, 32'h0C);
    bus_xfer(1'b0, 5'h08, 32'h0, 4'hF, 32'h0);
    bus_xfer(1'b1, 5'h00, 32'h13, 4'h0, 32'h0);
    bus_xfer(1'b1, 5'h08, 32'h13, 4'hF, 32'h0);
    bus_xfer(1'b0, 5'h00, 32'h0, 4'hF, 32'h0C);
    for (i = 0; i < 48; i++) begin
      rnd = {$urandom(), $urandom()};
      ctl[0] = {dec_q[i % 4][2:0], rnd[41:40]};
      ctl[1] = rnd[46:42];
      for (c = 0; c < 2; c++) begin
        bus_xfer(1'b1, 5'(4 * c), {rnd[63:37], 5'(ctl[c])}, 4'hF, 32'h0);
        bus_xfer(1'b0, 5'(4 * c), 32'h0, 4'hF, ctl[c]);
      end
      @(posedge clk_sys_i);
      set_inputs(rnd);
      repeat (8) @(posedge clk_sys_i);
      #1;
      model_check();
    end
    complete_run();
  end
endmodule // encoder_channel_pin_router_tb_top
